// ===== pkg/sfp_pkg.sv
package sfp_pkg;

  // address space and its decoding
  localparam int          SFP_ADDR_W       = 24;
  localparam int          SFP_SECTOR_SHIFT = 12;
  localparam int          SFP_BLK32_SHIFT  = 15;
  localparam int          SFP_BLK64_SHIFT  = 16;
  localparam int          SFP_SECTOR_W     = SFP_ADDR_W - SFP_SECTOR_SHIFT;
  localparam int          SFP_BLK32_W      = SFP_ADDR_W - SFP_BLK32_SHIFT;
  localparam int          SFP_BLK64_W      = SFP_ADDR_W - SFP_BLK64_SHIFT;
  localparam logic [23:0] SFP_SECTOR_SPAN  = 24'h000fff;

  // status bit that carries the quad-enable setting, and its default
  localparam int          SFP_QE_BIT       = 6;
  localparam logic        SFP_QE_RST       = 1'h0;

  // last step of a byte: 8 single-line steps or 2 quad-line steps
  localparam logic [2:0]  SFP_LAST_SINGLE  = 3'h7;
  localparam logic [2:0]  SFP_LAST_QUAD    = 3'h1;

  typedef struct packed {
    logic       drive;
    logic [7:0] data;
  } sfp_tx_t;

  typedef struct packed {
    logic [SFP_SECTOR_W-1:0] sector;
    logic [SFP_BLK32_W-1:0]  blk32;
    logic [SFP_BLK64_W-1:0]  blk64;
    logic [SFP_ADDR_W-1:0]   first;
    logic [SFP_ADDR_W-1:0]   last;
  } sfp_map_t;

  typedef enum logic [4:0] {
    SFP_ST_WAIT  = 5'h01,
    SFP_ST_IDLE  = 5'h02,
    SFP_ST_SEL   = 5'h04,
    SFP_ST_PAUSE = 5'h08,
    SFP_ST_HWRST = 5'h10
  } sfp_state_t;

endpackage

// ===== hdl/sfp_sync.sv
`timescale 1ns/1ps
module sfp_sync
  import sfp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst,
  input  wire logic         srst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_ff
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // first stage feeds only the second stage
  always_comb begin
    nxt_meta = meta_ff;
    nxt_q    = q_ff;
    if (!srst_n) begin
      nxt_meta = '0;
      nxt_q    = '0;
    end else if (en) begin
      nxt_meta = d;
      nxt_q    = meta_ff;
    end
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

endmodule

// ===== hdl/sfp_addr_decode.sv
`timescale 1ns/1ps
module sfp_addr_decode
  import sfp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  ce,
  input  wire logic                  req,
  input  wire logic [SFP_ADDR_W-1:0] addr,
  output sfp_map_t                   map_ff
);

  sfp_map_t nxt_map;

  always_comb begin
    nxt_map = map_ff;
    if (req) begin
      nxt_map.sector = addr[SFP_ADDR_W-1:SFP_SECTOR_SHIFT];          // [R14]
      nxt_map.blk32  = addr[SFP_ADDR_W-1:SFP_BLK32_SHIFT];           // [R15]
      nxt_map.blk64  = addr[SFP_ADDR_W-1:SFP_BLK64_SHIFT];           // [R15]
      nxt_map.first  = addr & ~SFP_SECTOR_SPAN;                      // [R16]
      nxt_map.last   = addr | SFP_SECTOR_SPAN;                       // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      map_ff <= '0;
    end else if (ce) begin
      map_ff <= nxt_map;
    end
  end

endmodule

// ===== hdl/sfp_pin_if.sv
// What this block does
// [R1] quad enable turns write-protect pin into line 2
// [R2] quad enable: pause pin is line 3
// [R3] pause suspends transfer, keeps partial sequence
// [R4] paused and selected: serial output high-z
// [R5] pause released: transfer continues where stopped
// [R6] reset pin high: normal operation
// [R7] reset pin low: reset state, outputs high-z
// [R8] master avoids reset during internal write
// [R9] only clock modes 0 and 3
// [R10] master parks clock per mode when idle
// [R11] inputs sampled on rising clock edge
// [R12] outputs launched on falling clock edge
// [R13] quad command mode uses all four lines
// [R14] memory in uniform 4 KB sectors
// [R15] 32/64 KB blocks of 8/16 sectors
// [R16] 24-bit address decodes to sectors 0..4095
// [R17] deselected: outputs high-z, no data taken
// [R18] single mode: in on line 0, out line 1
// [R19] quad enable is status bit 6, default 0
// [R20] paused: clock and input edges ignored
// [R21] after reset: idle until next select
`timescale 1ns/1ps
module sfp_pin_if
  import sfp_pkg::*;
#(
  parameter bit HOLD_AS_RESET = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  ce,
  input  wire logic                  reset_n,
  input  wire logic                  sck,
  input  wire logic                  cs_n,
  input  wire logic                  data_line_0_i,
  output logic                       data_line_0_o,
  output logic                       data_line_0_oe,
  input  wire logic                  data_line_1_i,
  output logic                       data_line_1_o,
  output logic                       data_line_1_oe,
  input  wire logic                  data_line_2_i,
  output logic                       data_line_2_o,
  output logic                       data_line_2_oe,
  input  wire logic                  data_line_3_i,
  output logic                       data_line_3_o,
  output logic                       data_line_3_oe,
  input  wire logic [7:0]            status_bits,
  input  wire logic                  quad_command_mode,
  input  wire logic                  tx_load,
  input  wire sfp_tx_t               tx_word,
  output logic [7:0]                 rx_data_ff,
  output logic                       rx_valid_ff,
  output logic                       selected_ff,
  output logic                       paused_ff,
  output logic                       hw_reset_ff,
  output logic                       write_protect_n_ff,
  input  wire logic                  map_req,
  input  wire logic [SFP_ADDR_W-1:0] map_addr,
  output sfp_map_t                   map_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration held in the system clock domain

  logic       qe_ff;
  logic       qm_ff;
  logic       pause_pin;
  logic       hwrst_pin;
  logic       frame_clr;
  logic       out_off;

  // pin 3 is data when quad enable is set, else pause or reset
  assign pause_pin = !qe_ff && !HOLD_AS_RESET && !data_line_3_i;  // [R2]
  assign hwrst_pin = !qe_ff &&  HOLD_AS_RESET && !data_line_3_i;  // [R2] [R6]
  // a high select pin or a low reset pin ends the frame's link state
  assign frame_clr = cs_n | hwrst_pin;                             // [R17] [R7]
  assign out_off   = frame_clr | pause_pin;                        // [R4]

  ////////////////////////////////////////////////////////////////////////////
  // link side, rising edge: capture (same edges in mode 0 and mode 3)

  logic [2:0] step_ff;
  logic [7:0] shift_ff;
  logic       rx_tog_ff;
  logic       tx_ack_ff;
  sfp_tx_t    tx_buf_ff;
  logic [7:0] rx_hold_ff;
  logic [2:0] nxt_step;
  logic [7:0] nxt_shift;
  logic       nxt_rx_tog;
  logic       nxt_tx_ack;
  sfp_tx_t    nxt_tx_buf;
  logic [7:0] nxt_rx_hold;
  logic       step_last;
  logic       tx_tog_ff;
  logic       tx_tog_sck;
  sfp_tx_t    tx_word_ff;

  sfp_sync #(.W(1)) u_tx_sync (
    .clk    (sck),
    .arst   (frame_clr),
    .srst_n (1'b1),
    .en     (1'b1),
    .d      (tx_tog_ff),
    .q_ff   (tx_tog_sck)
  );

  // qe_ff and qm_ff only change while deselected, so they are stable here
  always_comb begin
    nxt_step    = step_ff;
    nxt_shift   = shift_ff;
    nxt_rx_tog  = rx_tog_ff;
    nxt_tx_ack  = tx_ack_ff;
    nxt_tx_buf  = tx_buf_ff;
    nxt_rx_hold = rx_hold_ff;
    step_last   = qm_ff ? (step_ff == SFP_LAST_QUAD)
                        : (step_ff == SFP_LAST_SINGLE);
    if (!pause_pin) begin                                          // [R3] [R20]
      if (qm_ff) begin
        nxt_shift = {shift_ff[3:0], data_line_3_i, data_line_2_i,
                     data_line_1_i, data_line_0_i};                // [R13] [R11]
      end else begin
        nxt_shift = {shift_ff[6:0], data_line_0_i};                // [R18] [R11]
      end
      nxt_step = step_last ? 3'h0 : step_ff + 3'h1;
      if (step_last) begin
        nxt_rx_hold = nxt_shift;
        nxt_rx_tog  = !rx_tog_ff;
        if (tx_tog_sck != tx_ack_ff) begin
          nxt_tx_buf = tx_word_ff;
          nxt_tx_ack = !tx_ack_ff;
        end else begin
          nxt_tx_buf.drive = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sck or posedge frame_clr) begin  // [R9] [R11]
    if (frame_clr) begin
      step_ff   <= 3'h0;
      shift_ff  <= 8'h00;
      rx_tog_ff <= 1'b0;
      tx_ack_ff <= 1'b0;
      tx_buf_ff <= '0;
    end else begin
      step_ff   <= nxt_step;
      shift_ff  <= nxt_shift;
      rx_tog_ff <= nxt_rx_tog;
      tx_ack_ff <= nxt_tx_ack;
      tx_buf_ff <= nxt_tx_buf;
    end
  end

  // the last byte must outlive deselect until the system side reads it
  always_ff @(posedge sck or posedge hwrst_pin) begin
    if (hwrst_pin) begin
      rx_hold_ff <= 8'h00;
    end else begin
      rx_hold_ff <= nxt_rx_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side, falling edge: launch

  logic [3:0] dout_ff;
  logic [3:0] oe_ff;
  logic [3:0] nxt_dout;
  logic [3:0] nxt_oe;

  always_comb begin
    nxt_dout = dout_ff;
    nxt_oe   = oe_ff;
    if (!pause_pin) begin                                          // [R20]
      if (qm_ff) begin
        nxt_dout = step_ff[0] ? tx_buf_ff.data[3:0]
                              : tx_buf_ff.data[7:4];               // [R13] [R12]
        nxt_oe   = {4{tx_buf_ff.drive}};                           // [R13]
      end else begin
        nxt_dout = {2'b00, tx_buf_ff.data[SFP_LAST_SINGLE - step_ff],
                    1'b0};                                         // [R18] [R12]
        nxt_oe   = {2'b00, tx_buf_ff.drive, 1'b0};                 // [R18]
      end
    end
  end

  always_ff @(negedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      dout_ff <= 4'h0;
    end else begin
      dout_ff <= nxt_dout;
    end
  end

  // enables drop at once on deselect, pause or reset, with no clock edge
  always_ff @(negedge sck or posedge out_off) begin
    if (out_off) begin
      oe_ff <= 4'h0;                                               // [R4] [R7] [R17]
    end else begin
      oe_ff <= nxt_oe;                                             // [R5]
    end
  end

  assign data_line_0_o  = dout_ff[0];
  assign data_line_1_o  = dout_ff[1];
  assign data_line_2_o  = dout_ff[2];
  assign data_line_3_o  = dout_ff[3];
  assign data_line_0_oe = oe_ff[0];
  assign data_line_1_oe = oe_ff[1];
  assign data_line_2_oe = oe_ff[2];
  assign data_line_3_oe = oe_ff[3];

  ////////////////////////////////////////////////////////////////////////////
  // system side: synchronisers and link state

  logic       cs_s;
  logic       pin3_low_s;
  logic       pin2_low_s;
  logic       rx_tog_s;
  logic       hwrst_s;
  logic       pause_s;
  logic       in_frame;
  sfp_state_t state_ff;
  sfp_state_t nxt_state;

  sfp_sync #(.W(4)) u_pin_sync (
    .clk    (mclk),
    .arst   (1'b0),
    .srst_n (reset_n),
    .en     (ce),
    // pins 2 and 3 kept inverted so a flushed stage reads as released
    .d      ({cs_n, ~data_line_3_i, ~data_line_2_i, rx_tog_ff}),
    .q_ff   ({cs_s, pin3_low_s, pin2_low_s, rx_tog_s})
  );

  assign hwrst_s  = !qe_ff &&  HOLD_AS_RESET && pin3_low_s;
  assign pause_s  = !qe_ff && !HOLD_AS_RESET && pin3_low_s;
  assign in_frame = (state_ff == SFP_ST_SEL) || (state_ff == SFP_ST_PAUSE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SFP_ST_WAIT:  nxt_state = cs_s ? SFP_ST_IDLE : SFP_ST_WAIT;  // [R17] [R21]
      SFP_ST_IDLE:  nxt_state = cs_s ? SFP_ST_IDLE : SFP_ST_SEL;
      SFP_ST_SEL: begin
        if (cs_s) begin
          nxt_state = SFP_ST_IDLE;
        end else if (pause_s) begin
          nxt_state = SFP_ST_PAUSE;                                // [R3]
        end
      end
      SFP_ST_PAUSE: begin
        if (cs_s) begin
          nxt_state = SFP_ST_IDLE;
        end else if (!pause_s) begin
          nxt_state = SFP_ST_SEL;                                  // [R5]
        end
      end
      SFP_ST_HWRST: nxt_state = SFP_ST_WAIT;                       // [R21]
      default:      nxt_state = SFP_ST_WAIT;
    endcase
    if (hwrst_s) begin
      nxt_state = SFP_ST_HWRST;                                    // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system side: byte hand-over in both directions

  logic       rx_seen_ff;
  logic       nxt_rx_seen;
  logic [7:0] nxt_rx_data;
  logic       nxt_rx_valid;
  logic       nxt_tx_tog;
  sfp_tx_t    nxt_tx_word;
  logic       nxt_qe;
  logic       nxt_qm;
  logic       nxt_wp_n;

  always_comb begin
    nxt_rx_seen  = rx_tog_s;
    nxt_rx_data  = rx_data_ff;
    nxt_rx_valid = 1'b0;
    nxt_tx_tog   = tx_tog_ff;
    nxt_tx_word  = tx_word_ff;
    nxt_qe       = qe_ff;
    nxt_qm       = qm_ff;
    if (in_frame) begin
      // the link clears its toggle on deselect; that edge is no byte
      if (rx_tog_s != rx_seen_ff && !cs_s && !hwrst_s) begin
        nxt_rx_data  = rx_hold_ff;
        nxt_rx_valid = 1'b1;
      end
      if (tx_load) begin
        nxt_tx_word = tx_word;
        nxt_tx_tog  = !tx_tog_ff;
      end
    end else begin
      // link side clears its toggles on deselect; follow it here
      nxt_tx_tog = 1'b0;
      nxt_qe     = status_bits[SFP_QE_BIT];                        // [R19]
      nxt_qm     = quad_command_mode;
    end
    // write protect has no meaning once its pin carries data
    nxt_wp_n = qe_ff ? 1'b1 : !pin2_low_s;                         // [R1]
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff           <= SFP_ST_WAIT;
      rx_seen_ff         <= 1'b0;
      rx_data_ff         <= 8'h00;
      rx_valid_ff        <= 1'b0;
      tx_tog_ff          <= 1'b0;
      tx_word_ff         <= '0;
      qe_ff              <= SFP_QE_RST;                            // [R19]
      qm_ff              <= 1'b0;
      write_protect_n_ff <= 1'b1;
      selected_ff        <= 1'b0;
      paused_ff          <= 1'b0;
      hw_reset_ff        <= 1'b0;
    end else if (ce) begin
      state_ff           <= nxt_state;
      rx_seen_ff         <= nxt_rx_seen;
      rx_data_ff         <= nxt_rx_data;
      rx_valid_ff        <= nxt_rx_valid;
      tx_tog_ff          <= nxt_tx_tog;
      tx_word_ff         <= nxt_tx_word;
      qe_ff              <= nxt_qe;
      qm_ff              <= nxt_qm;
      write_protect_n_ff <= nxt_wp_n;
      selected_ff        <= (nxt_state == SFP_ST_SEL) ||
                            (nxt_state == SFP_ST_PAUSE);
      paused_ff          <= (nxt_state == SFP_ST_PAUSE);
      hw_reset_ff        <= (nxt_state == SFP_ST_HWRST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sector and block map of an address

  sfp_addr_decode u_map (
    .clk     (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .req     (map_req),
    .addr    (map_addr),
    .map_ff  (map_ff)
  );

endmodule

// ===== testbench/sfp_chk.sv
`timescale 1ns/1ps
module sfp_chk
  import sfp_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire logic                  ce,
  input wire logic                  sck,
  input wire logic                  cs_n,
  input wire logic                  data_line_0_oe,
  input wire logic                  data_line_1_o,
  input wire logic                  data_line_1_oe,
  input wire logic                  data_line_2_i,
  input wire logic                  data_line_2_oe,
  input wire logic                  data_line_3_i,
  input wire logic                  data_line_3_oe,
  input wire logic [7:0]            status_bits,
  input wire logic                  quad_command_mode,
  input wire logic                  rx_valid_ff,
  input wire logic                  selected_ff,
  input wire logic                  paused_ff,
  input wire logic                  write_protect_n_ff,
  input wire logic                  map_req,
  input wire logic [SFP_ADDR_W-1:0] map_addr,
  input wire sfp_map_t              map_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  a_deselect_hiz: assert property (
    cs_n |-> !(data_line_0_oe || data_line_1_oe || data_line_2_oe
               || data_line_3_oe))
    else $error("line driven while deselected");
  a_pause_hiz: assert property (
    (!cs_n && !data_line_3_i && !status_bits[6] && !quad_command_mode)
      |-> !data_line_1_oe)
    else $error("output driven while paused");
  // falling edges are at least 7.5 ns from the next rise, so sck low here
  a_launch_falling: assert property (
    disable iff (!reset_n || cs_n) $changed(data_line_1_o) |-> !sck)
    else $error("output bit changed outside a falling edge");
  a_wp_forced: assert property (
    (cs_n && status_bits[6]) [*6] |-> write_protect_n_ff)
    else $error("write protect not released by quad enable");
  a_wp_follows: assert property (
    (cs_n && !status_bits[6] && !data_line_2_i) [*6]
      |-> !write_protect_n_ff)
    else $error("write protect level lost");
  a_map_sector: assert property (
    (map_req && ce) |=> map_ff.sector == $past(map_addr[23:12])
      && map_ff.first == {$past(map_addr[23:12]), 12'h000}
      && map_ff.last == ({$past(map_addr[23:12]), 12'h000}
                         | SFP_SECTOR_SPAN))
    else $error("sector decode wrong");
  a_map_blocks: assert property (
    (map_req && ce) |=> map_ff.blk32 == $past(map_addr[23:15])
      && map_ff.blk64 == $past(map_addr[23:16]))
    else $error("block decode wrong");
  a_valid_pulse: assert property (
    rx_valid_ff |=> !rx_valid_ff)
    else $error("byte report longer than one cycle");
  a_idle_quiet: assert property (
    cs_n [*8] |-> !(rx_valid_ff || selected_ff || paused_ff))
    else $error("activity while deselected");
  a_pause_seen: assert property (
    (!cs_n && !data_line_3_i && !status_bits[6] && selected_ff) [*6]
      |-> paused_ff)
    else $error("pause not reported");
  a_quad_nopause: assert property (
    status_bits[6] [*8] |-> !paused_ff)
    else $error("pause taken with quad lines on");
endmodule

bind sfp_pin_if sfp_chk sfp_chk_i (
  .mclk(mclk), .reset_n(reset_n), .ce(ce), .sck(sck), .cs_n(cs_n),
  .data_line_0_oe(data_line_0_oe), .data_line_1_o(data_line_1_o),
  .data_line_1_oe(data_line_1_oe), .data_line_2_i(data_line_2_i),
  .data_line_2_oe(data_line_2_oe), .data_line_3_i(data_line_3_i),
  .data_line_3_oe(data_line_3_oe), .status_bits(status_bits),
  .quad_command_mode(quad_command_mode), .rx_valid_ff(rx_valid_ff),
  .selected_ff(selected_ff), .paused_ff(paused_ff),
  .write_protect_n_ff(write_protect_n_ff), .map_req(map_req),
  .map_addr(map_addr), .map_ff(map_ff));

// ===== testbench/sfp_master.sv
`timescale 1ns/1ps
module sfp_master (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] m_out,
  output logic [3:0] m_oe,
  input  wire logic [3:0] line
);
  logic       mode3 = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  // lines 2 and 3 idle high: write protect off, pause off
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b0;
    m_out = 4'hc;
    m_oe  = 4'hd;
    // link side has no reset of its own: a deselect edge clears all of it but rx_hold_ff
    #1 cs_n = 1'b1;
  end
  ////////////////////////////////////////
  task automatic open_frame(input logic m3);
    mode3 = m3;
    sck   = m3;
    #15 cs_n = 1'b0;
    #30;
  endtask
  task automatic close_frame();
    sck = mode3;
    #7.5 cs_n = 1'b1;
    m_oe     = 4'hd;
    m_out[3] = 1'b1;
    #30;
  endtask
  task automatic bits(input int n, input logic quad);
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      if (quad) begin
        m_oe  = 4'hf;
        m_out = sh[7:4];
        sh    = sh << 4;
      end else begin
        m_out[0] = sh[7];
        sh       = sh << 1;
      end
      #7.5 sck = 1'b1;
      rx = {rx[6:0], line[1]};
      #7.5;
    end
  endtask
  // pause only moves with sck low, so no edge is half taken
  task automatic hold(input logic lvl);
    sck = 1'b0;
    #7.5 m_out[3] = lvl;
    #7.5;
  endtask
  task automatic wiggle(input int n);
    for (int i = 0; i < n; i++) begin
      m_out[0] = ~m_out[0];
      #7.5 sck = ~sck;
    end
  endtask
endmodule

// ===== testbench/sfp_pin_if_bench.sv
`timescale 1ns/1ps
module sfp_pin_if_bench;
  import sfp_pkg::*;
  logic        mclk;
  logic        flt = 1'b0;
  logic        reset_n;
  logic        ce;
  logic [7:0]  status_bits;
  logic        quad_command_mode;
  logic        tx_load;
  sfp_tx_t     tx_word;
  logic        map_req;
  logic [23:0] map_addr;
  logic        sck, cs_n, rx_valid_ff, selected_ff, paused_ff;
  logic        hw_reset_ff, write_protect_n_ff;
  logic [3:0]  m_out, m_oe, d_o, d_oe, line;
  logic [7:0]  rx_data_ff;
  logic [7:0]  got = 8'h00;
  sfp_map_t    map_ff;
  int          failures = 0;
  int          comparisons = 0;
  int          ngot = 0;
  int          want = 0;
  int          cycles = 0;
  always #2 mclk = ~mclk;
  // undriven lines toggle so a stale level is never mistaken for data
  always @(posedge mclk) flt <= ~flt;
  assign line = (d_oe & d_o) | (~d_oe & m_oe & m_out)
              | (~d_oe & ~m_oe & {4{flt}});
  sfp_pin_if #(.HOLD_AS_RESET(1'b0)) sfp_pin_if_i (
    .mclk(mclk), .ce(ce), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
    .data_line_0_i(line[0]), .data_line_0_o(d_o[0]),
    .data_line_0_oe(d_oe[0]), .data_line_1_i(line[1]),
    .data_line_1_o(d_o[1]), .data_line_1_oe(d_oe[1]),
    .data_line_2_i(line[2]), .data_line_2_o(d_o[2]),
    .data_line_2_oe(d_oe[2]), .data_line_3_i(line[3]),
    .data_line_3_o(d_o[3]), .data_line_3_oe(d_oe[3]),
    .status_bits(status_bits), .quad_command_mode(quad_command_mode),
    .tx_load(tx_load), .tx_word(tx_word), .rx_data_ff(rx_data_ff),
    .rx_valid_ff(rx_valid_ff), .selected_ff(selected_ff),
    .paused_ff(paused_ff), .hw_reset_ff(hw_reset_ff),
    .write_protect_n_ff(write_protect_n_ff), .map_req(map_req),
    .map_addr(map_addr), .map_ff(map_ff));
  sfp_master sfp_master_i (
    .sck(sck), .cs_n(cs_n), .m_out(m_out), .m_oe(m_oe), .line(line));
  ////////////////////////////////////////
  always @(posedge mclk) begin
    if (rx_valid_ff) begin
      got  <= rx_data_ff;
      ngot <= ngot + 1;
    end
  end
  task automatic finish_test();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] v, input logic q);
    sfp_master_i.sh = v;
    sfp_master_i.bits(q ? 2 : 8, q);
  endtask
  task automatic expect_rx(input int n, input logic [7:0] v);
    want += n;
    repeat (8) @(negedge mclk);
    chk(ngot, want);
    chk(got, v);
  endtask
  // the word must land two rising edges before the boundary to be used
  task automatic load_frame(input logic [7:0] b, input logic [7:0] t);
    sfp_master_i.open_frame(1'b0);
    fork
      send(b, 1'b0);
      begin
        repeat (4) @(posedge mclk);
        tx_word <= {1'b1, t};
        tx_load <= 1'b1;
        @(posedge mclk);
        tx_load <= 1'b0;
      end
    join
  endtask
  ////////////////////////////////////////
  task automatic sc_map();
    logic [23:0] a [4];
    a = '{24'h000000, 24'h00ffff, 24'h7f0123, 24'hffffff};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      map_req  <= 1'b1;
      map_addr <= a[i];
      @(posedge mclk);
      map_req <= 1'b0;
      repeat (2) @(negedge mclk);
      chk(map_ff.sector, a[i][23:12]);
      chk(map_ff.blk32, a[i][23:15]);
      chk(map_ff.blk64, a[i][23:16]);
      chk(map_ff.first, {a[i][23:12], 12'h000});
      chk(map_ff.last, {a[i][23:12], 12'hfff});
    end
  endtask
  // ce low freezes the map even with a request standing
  task automatic sc_freeze();
    @(posedge mclk);
    ce       <= 1'b0;
    map_req  <= 1'b1;
    map_addr <= 24'h123456;
    @(posedge mclk);
    map_req <= 1'b0;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(map_ff.first, 24'hfff000);
  endtask
  task automatic sc_single();
    for (int m = 0; m < 2; m++) begin
      sfp_master_i.open_frame(m[0]);
      send(8'ha5 ^ m[7:0], 1'b0);
      send(8'h3c ^ m[7:0], 1'b0);
      sfp_master_i.close_frame();
      expect_rx(2, 8'h3c ^ m[7:0]);
    end
  endtask
  task automatic sc_deselect();
    sfp_master_i.open_frame(1'b0);
    sfp_master_i.sh = 8'hff;
    sfp_master_i.bits(5, 1'b0);
    sfp_master_i.close_frame();
    sfp_master_i.wiggle(4);
    sfp_master_i.open_frame(1'b0);
    send(8'h81, 1'b0);
    sfp_master_i.close_frame();
    expect_rx(1, 8'h81);
    chk(selected_ff, 1'b0);
  endtask
  task automatic sc_transmit();
    load_frame(8'h11, 8'hc6);
    send(8'h22, 1'b0);
    chk(sfp_master_i.rx, 8'hc6);
    sfp_master_i.close_frame();
    expect_rx(2, 8'h22);
  endtask
  task automatic sc_pause();
    load_frame(8'h0f, 8'h5a);
    sfp_master_i.sh = 8'h96;
    sfp_master_i.bits(4, 1'b0);
    @(negedge mclk);
    chk(d_oe[1], 1'b1);
    sfp_master_i.hold(1'b0);
    sfp_master_i.wiggle(4);
    repeat (6) @(negedge mclk);
    chk(paused_ff, 1'b1);
    chk(d_oe[1], 1'b0);
    chk(hw_reset_ff, 1'b0);
    sfp_master_i.hold(1'b1);
    sfp_master_i.bits(4, 1'b0);
    sfp_master_i.close_frame();
    expect_rx(2, 8'h96);
  endtask
  task automatic sc_quad();
    sfp_master_i.m_out[2] = 1'b0;
    repeat (8) @(negedge mclk);
    chk(write_protect_n_ff, 1'b0);
    @(posedge mclk);
    status_bits       <= 8'h40;
    quad_command_mode <= 1'b1;
    repeat (8) @(negedge mclk);
    chk(write_protect_n_ff, 1'b1);
    sfp_master_i.open_frame(1'b1);
    send(8'h5a, 1'b1);
    sfp_master_i.close_frame();
    expect_rx(1, 8'h5a);
    @(posedge mclk);
    status_bits       <= 8'h00;
    quad_command_mode <= 1'b0;
    sfp_master_i.m_out[2] = 1'b1;
  endtask
  ////////////////////////////////////////
  initial begin
    mclk              = 1'b0;
    reset_n           = 1'b0;
    ce                = 1'b1;
    status_bits       = 8'h00;
    quad_command_mode = 1'b0;
    tx_load           = 1'b0;
    tx_word           = '0;
    map_req           = 1'b0;
    map_addr          = 24'h000000;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
    sc_map();
    sc_freeze();
    sc_single();
    sc_deselect();
    sc_transmit();
    sc_pause();
    sc_quad();
    finish_test();
  end
endmodule
